// ===== logic/duc_channel_control.v
// duart channel pair: mode, command, status and output port logic
`timescale 1ns/10ps
`include "duc_defines.vh"
module duc_channel_control (
	input wire clk,
	input wire nrst,
	input wire busSelN,
	input wire busRead,
	input wire [3:0] busAddr,
	input wire [7:0] busWrData,
	output reg [7:0] busRdData_q,
	input wire [1:0] rxCharValid,
	input wire [15:0] rxCharData,
	input wire [5:0] rxCharErr,
	input wire [1:0] rxStartBit,
	output wire [1:0] rxCharReady,
	output wire [1:0] txCharValid,
	output wire [15:0] txCharData,
	input wire [1:0] txCharTaken,
	input wire [1:0] txBusy,
	input wire [1:0] ctsN,
	output wire [1:0] txBreak,
	output wire [1:0] rxEnable,
	output wire [1:0] txEnable,
	output wire [15:0] clockSelect,
	output wire [7:0] dataBits,
	output wire [1:0] parityOn,
	output wire [1:0] parityForced,
	output wire [1:0] parityValue,
	output wire [1:0] multidrop,
	output wire [11:0] stopSixteenths,
	output wire [1:0] echoMode,
	output wire [1:0] localLoop,
	output wire [1:0] remoteLoop,
	input wire ctOutput,
	input wire txClk16xA,
	input wire [1:0] txClk1x,
	input wire [1:0] rxClk1x,
	output reg [7:0] outputPortPin_q
);
	// ************************************************************
	// reset release
	// ************************************************************
	reg [1:0] rstSync_q; // release synchroniser
	wire rstN = rstSync_q[1];

	// assert at once, release after two clean edges
	always @(posedge clk or negedge nrst) begin
		if (!nrst)
			rstSync_q <= 2'b00;
		else
			rstSync_q <= {rstSync_q[0], 1'b1};
	end

	// ************************************************************
	// bus decode
	// ************************************************************
	wire access = ~busSelN; // one cycle strobe per access
	wire wrAcc = access & ~busRead;
	wire rdAcc = access & busRead;
	wire [15:0] chanRd; // read byte of each channel
	wire [1:0] rtsHold; // receiver flow control hold
	wire [1:0] rxSelBit; // selected receive status
	wire [1:0] txRdyBit; // transmitter ready
	wire [1:0] txRtsDrop; // transmitter done, drop request

	// four way pick for the clock routed pins
	function pick4;
		input [1:0] sel;
		input a;
		input b;
		input c;
		input d;
		begin
			case (sel)
				2'b00: pick4 = a;
				2'b01: pick4 = b;
				2'b10: pick4 = c;
				default: pick4 = d;
			endcase
		end
	endfunction

	// ************************************************************
	// per channel logic, index 0 is a, 1 is b
	// ************************************************************
	genvar c;
	generate
		for (c = 0; c < 2; c = c + 1) begin : chan
			localparam [3:0] OFS = (c == 0) ? 4'h0 : `DUC_B_OFS;
			reg [7:0] modeOne_q; // mode register one
			reg [7:0] modeTwo_q; // mode register two
			reg [7:0] clkSel_q; // clock select, write only
			reg [7:0] thr_q; // transmit holding byte
			reg ptrTwo_q; // mode pointer at register two
			reg rxEn_q;
			reg txEn_q;
			reg thrFull_q;
			reg txValid_q;
			reg overrun_q;
			reg rtsHold_q;
			reg brk_q;
			reg headSeen_q; // fifo top already accumulated
			reg headMask_q; // fifo top flags cleared by command
			reg [2:0] errAcc_q; // block mode error accumulation
			wire fifoReady;
			wire headValid;
			wire [10:0] head;
			wire hitMode = access & (busAddr == (`DUC_A_MODE | OFS));
			wire hitStat = access & (busAddr == (`DUC_A_STAT | OFS));
			wire hitCmd = wrAcc & (busAddr == (`DUC_A_CMD | OFS));
			wire hitData = access & (busAddr == (`DUC_A_DATA | OFS));
			// bit 7 is not decoded at all
			wire [2:0] misc = busWrData[6:4];
			// commands act in their access cycle; the host keeps
			// upper-nibble writes apart, so no queue is kept
			wire cmdPtr = hitCmd & (misc == `DUC_CMD_PTR);
			wire cmdRxRst = hitCmd & (misc == `DUC_CMD_RXRST);
			wire cmdTxRst = hitCmd & (misc == `DUC_CMD_TXRST);
			wire cmdErrRst = hitCmd & (misc == `DUC_CMD_ERRRST);
			wire cmdBrkOn = hitCmd & (misc == `DUC_CMD_BRKON);
			wire cmdBrkOff = hitCmd & (misc == `DUC_CMD_BRKOFF);
			wire multi = (modeOne_q[4:3] == `DUC_PAR_MDROP);
			// a disabled multidrop receiver keeps address chars only
			wire accept = rxEn_q | (multi & rxCharErr[3*c]);
			wire rdData = hitData & busRead;
			wire pop = rdData & headValid;
			wire fifoFull = ~fifoReady;
			wire transmit_holding_free = txEn_q & ~thrFull_q;
			wire transmitter_idle_empty = transmit_holding_free & ~txBusy[c];
			wire blockMode = modeOne_q[`DUC_M1_ERRBLK];
			wire [2:0] charErr = (headValid & ~headMask_q) ?
				head[10:8] : 3'b000;
			wire [2:0] errShown = blockMode ?
				errAcc_q : charErr;
			wire [7:0] status = {errShown, overrun_q, transmitter_idle_empty, transmit_holding_free,
				fifoFull, headValid};
			wire take = txValid_q & txCharTaken[c];
			wire ctsOk = ~modeTwo_q[`DUC_M2_CTSEN] | ~ctsN[c];
			wire thrLoad = hitData & ~busRead & txEn_q;
			wire thrFullD = ~cmdTxRst & (thrLoad | (thrFull_q & ~take));
			wire arrive = headValid & ~headSeen_q & ~cmdRxRst;
			wire errClr = cmdErrRst | cmdRxRst;

			// error flags ride in the fifo word beside the data
			duc_fifo #(
				.WIDTH(8 + `DUC_ERR_W),
				.DEPTH(`DUC_FIFO_DEPTH),
				.AW(3)
			) rxFifo (
				.clk(clk),
				.rstN(rstN),
				.flush(cmdRxRst),
				.inValid(rxCharValid[c] & accept),
				.inData({rxCharErr[3*c+2:3*c],
					rxCharData[8*c+7:8*c]}),
				.inReady_q(fifoReady),
				.outValid(headValid),
				.outData(head),
				.outReady(rdData)
			);

			// format decode handed to the serial engines
			duc_frame_fmt frameFmt (
				.clk(clk),
				.rstN(rstN),
				.modeOne(modeOne_q),
				.modeTwo(modeTwo_q),
				.dataBits_q(dataBits[4*c+3:4*c]),
				.parityOn_q(parityOn[c]),
				.parityForced_q(parityForced[c]),
				.parityValue_q(parityValue[c]),
				.multidrop_q(multidrop[c]),
				.stopSixteenths_q(stopSixteenths[6*c+5:6*c]),
				.echoMode_q(echoMode[c]),
				.localLoop_q(localLoop[c]),
				.remoteLoop_q(remoteLoop[c])
			);

			// channel control state
			always @(posedge clk or negedge rstN) begin
				if (!rstN) begin
					modeOne_q <= `DUC_REG_RST;
					modeTwo_q <= `DUC_REG_RST;
					clkSel_q <= `DUC_REG_RST;
					thr_q <= `DUC_REG_RST;
					ptrTwo_q <= 1'b0;
					rxEn_q <= 1'b0;
					txEn_q <= 1'b0;
					thrFull_q <= 1'b0;
					txValid_q <= 1'b0;
					overrun_q <= 1'b0;
					rtsHold_q <= 1'b0;
					brk_q <= 1'b0;
					headSeen_q <= 1'b0;
					headMask_q <= 1'b0;
					errAcc_q <= 3'b000;
				end else begin
					// mode access goes through the pointer
					if (hitMode & ~busRead & ~ptrTwo_q)
						modeOne_q <= busWrData;
					if (hitMode & ~busRead & ptrTwo_q)
						modeTwo_q <= busWrData;
					if (cmdPtr)
						ptrTwo_q <= 1'b0;
					else if (hitMode)
						ptrTwo_q <= 1'b1;
					if (hitStat & ~busRead)
						clkSel_q <= busWrData;
					// disable wins over enable in one write
					if (cmdRxRst | (hitCmd & busWrData[`DUC_CR_RXDIS]))
						rxEn_q <= 1'b0;
					else if (hitCmd & busWrData[`DUC_CR_RXEN])
						rxEn_q <= 1'b1;
					if (cmdTxRst | (hitCmd & busWrData[`DUC_CR_TXDIS]))
						txEn_q <= 1'b0;
					else if (hitCmd & busWrData[`DUC_CR_TXEN])
						txEn_q <= 1'b1;
					// holding register, loaded only when enabled
					thrFull_q <= thrFullD;
					if (thrLoad)
						thr_q <= busWrData;
					// with cts enable set in mode two, a character starts only with clear to send
					txValid_q <= thrFullD & ctsOk;
					// new start bit with the shifter still stuck
					if (rxStartBit[c] & rxCharValid[c] & fifoFull)
						overrun_q <= 1'b1;
					else if (errClr)
						overrun_q <= 1'b0;
					// mark the top entry once it has been seen
					if (pop | cmdRxRst)
						headSeen_q <= 1'b0;
					else if (headValid)
						headSeen_q <= 1'b1;
					if (pop | cmdRxRst)
						headMask_q <= 1'b0;
					else if (cmdErrRst)
						headMask_q <= 1'b1;
					// new arrival ors in even during an error reset, not on a receiver reset
					errAcc_q <= (errClr ? 3'b000 : errAcc_q) |
						(arrive ? head[10:8] : 3'b000);
					// hold request low until a slot frees
					if (modeOne_q[`DUC_M1_RECEIVER_FLOW_CONTROL] & rxStartBit[c] & fifoFull)
						rtsHold_q <= 1'b1;
					else if (fifoReady | ~modeOne_q[`DUC_M1_RECEIVER_FLOW_CONTROL])
						rtsHold_q <= 1'b0;
					if (cmdBrkOn)
						brk_q <= 1'b1;
					else if (cmdBrkOff | cmdTxRst)
						brk_q <= 1'b0;
				end
			end

			// read byte; write only and unused addresses read zero
			assign chanRd[8*c+7:8*c] = ~busRead ? 8'h00 :
				hitMode ? (ptrTwo_q ? modeTwo_q : modeOne_q) :
				hitStat ? status :
				hitData ? head[7:0] : 8'h00;
			assign rtsHold[c] = rtsHold_q;
			assign rxSelBit[c] = modeOne_q[`DUC_M1_RXINT] ?
				fifoFull : headValid;
			assign txRdyBit[c] = transmit_holding_free;
			// drop request once the disabled transmitter drains
			assign txRtsDrop[c] = modeTwo_q[`DUC_M2_TRANSMITTER_FLOW_CONTROL] & ~txEn_q &
				~thrFull_q & ~txBusy[c];
			assign rxCharReady[c] = fifoReady;
			assign txCharValid[c] = txValid_q;
			assign txCharData[8*c+7:8*c] = thr_q;
			assign txBreak[c] = brk_q;
			assign rxEnable[c] = rxEn_q;
			assign txEnable[c] = txEn_q;
			assign clockSelect[8*c+7:8*c] = clkSel_q;
		end
	endgenerate

	// ************************************************************
	// output port and read answer
	// ************************************************************
	reg [7:0] output_pin_config_q; // output pin configuration
	reg [7:0] opr_q; // output latch
	wire wrOpcr = wrAcc & (busAddr == `DUC_OUTPUT_PIN_CONFIG);
	wire oprSet = wrAcc & (busAddr == `DUC_OPSET);
	wire oprClr = wrAcc & (busAddr == `DUC_OPCLR);
	wire [7:0] setMask = oprSet ? busWrData : 8'h00;
	wire [7:0] clrMask = oprClr ? busWrData : 8'h00;
	// pin sources before the inversion
	wire [7:0] pinSrc = {
		output_pin_config_q[7] ? txRdyBit[1] : opr_q[7],
		output_pin_config_q[6] ? txRdyBit[0] : opr_q[6],
		output_pin_config_q[5] ? rxSelBit[1] : opr_q[5],
		output_pin_config_q[4] ? rxSelBit[0] : opr_q[4],
		pick4(output_pin_config_q[3:2], opr_q[3], ctOutput,
			txClk1x[1], rxClk1x[1]),
		pick4(output_pin_config_q[1:0], opr_q[2], txClk16xA,
			txClk1x[0], rxClk1x[0]),
		opr_q[1] & ~rtsHold[1],
		opr_q[0] & ~rtsHold[0]};

	// latch, configuration, pins and the read answer
	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			output_pin_config_q <= `DUC_REG_RST;
			opr_q <= `DUC_REG_RST;
			outputPortPin_q <= `DUC_PIN_RST;
			busRdData_q <= `DUC_REG_RST;
		end else begin
			if (wrOpcr)
				output_pin_config_q <= busWrData;
			// set and reset bit commands; transmit done drops rts
			opr_q <= (opr_q | setMask) & ~clrMask &
				~{6'b000000, txRtsDrop};
			// pins are low while the source bit is one
			outputPortPin_q <= ~pinSrc;
			if (rdAcc)
				busRdData_q <= chanRd[7:0] | chanRd[15:8];
		end
	end
endmodule

// ===== logic/duc_defines.vh
// constants shared by the duart channel control files
`ifndef DUC_DEFINES_VH
`define DUC_DEFINES_VH
// ************************************************************
// register addresses (address pins a4..a1)
// ************************************************************
`define DUC_A_MODE 4'h0
`define DUC_A_STAT 4'h1
`define DUC_A_CMD 4'h2
`define DUC_A_DATA 4'h3
`define DUC_B_OFS 4'h8
`define DUC_OUTPUT_PIN_CONFIG 4'hd
`define DUC_OPSET 4'he
`define DUC_OPCLR 4'hf
`define DUC_REG_RST 8'h00
`define DUC_PIN_RST 8'hff
// ************************************************************
// field positions and encodings
// ************************************************************
`define DUC_M1_RECEIVER_FLOW_CONTROL 7
`define DUC_M1_RXINT 6
`define DUC_M1_ERRBLK 5
`define DUC_M1_PTYPE 2
`define DUC_PAR_ON 2'b00
`define DUC_PAR_FORCE 2'b01
`define DUC_PAR_OFF 2'b10
`define DUC_PAR_MDROP 2'b11
`define DUC_M2_TRANSMITTER_FLOW_CONTROL 5
`define DUC_M2_CTSEN 4
`define DUC_CM_ECHO 2'b01
`define DUC_CM_LLOOP 2'b10
`define DUC_CM_RLOOP 2'b11
`define DUC_LEN5 2'b00
`define DUC_BITS_MIN 4'h5
`define DUC_STOP_BASE 6'h09
`define DUC_STOP_LONG 6'h11
`define DUC_STOP_HALF 6'h08
`define DUC_CR_RXEN 0
`define DUC_CR_RXDIS 1
`define DUC_CR_TXEN 2
`define DUC_CR_TXDIS 3
`define DUC_CMD_PTR 3'h1
`define DUC_CMD_RXRST 3'h2
`define DUC_CMD_TXRST 3'h3
`define DUC_CMD_ERRRST 3'h4
`define DUC_CMD_BRKON 3'h6
`define DUC_CMD_BRKOFF 3'h7
`define DUC_FIFO_DEPTH 8
`define DUC_ERR_W 3
`endif

// ===== logic/duc_fifo.v
// receive fifo with valid and ready on both sides
`timescale 1ns/10ps
`include "duc_defines.vh"
module duc_fifo #(
	parameter WIDTH = 11,
	parameter DEPTH = `DUC_FIFO_DEPTH,
	parameter AW = 3
) (
	input wire clk,
	input wire rstN,
	input wire flush,
	input wire inValid,
	input wire [WIDTH-1:0] inData,
	output reg inReady_q,
	output wire outValid,
	output wire [WIDTH-1:0] outData,
	input wire outReady
);
	reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage, no reset needed
	reg [AW-1:0] wrPtr_q;
	reg [AW-1:0] rdPtr_q;
	reg [AW:0] count_q;
	wire push = inValid & inReady_q;
	wire pop = outValid & outReady;
	wire [AW:0] count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

	// wrap a pointer at the last slot
	function [AW-1:0] bump;
		input [AW-1:0] p;
		begin
			if (p == DEPTH - 1)
				bump = {AW{1'b0}};
			else
				bump = p + 1'b1;
		end
	endfunction

	assign outValid = (count_q != {(AW+1){1'b0}});
	assign outData = mem[rdPtr_q];

	// data array write
	always @(posedge clk) begin
		if (push)
			mem[wrPtr_q] <= inData;
	end

	// pointers; ready is a flop so back-pressure is glitch free
	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			wrPtr_q <= {AW{1'b0}};
			rdPtr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
			inReady_q <= 1'b1;
		end else if (flush) begin
			// realign only: old words stay in the array
			wrPtr_q <= {AW{1'b0}};
			rdPtr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
			inReady_q <= 1'b1;
		end else begin
			if (push)
				wrPtr_q <= bump(wrPtr_q);
			if (pop)
				rdPtr_q <= bump(rdPtr_q);
			count_q <= count_d;
			inReady_q <= (count_d != DEPTH);
		end
	end
endmodule

// ===== logic/duc_frame_fmt.v
// character format decode for one channel, registered outputs
`timescale 1ns/10ps
`include "duc_defines.vh"
module duc_frame_fmt (
	input wire clk,
	input wire rstN,
	input wire [7:0] modeOne,
	input wire [7:0] modeTwo,
	output reg [3:0] dataBits_q,
	output reg parityOn_q,
	output reg parityForced_q,
	output reg parityValue_q,
	output reg multidrop_q,
	output reg [5:0] stopSixteenths_q,
	output reg echoMode_q,
	output reg localLoop_q,
	output reg remoteLoop_q
);
	wire [1:0] parMode = modeOne[4:3];

	// stop time in sixteenths of a bit
	function [5:0] stopLen;
		input [3:0] code;
		input five;
		begin
			if (code[3])
				stopLen = `DUC_STOP_LONG + {2'b00, code};
			else if (five)
				stopLen = `DUC_STOP_BASE + `DUC_STOP_HALF + {2'b00, code};
			else
				stopLen = `DUC_STOP_BASE + {2'b00, code};
		end
	endfunction

	// decode mode fields once per cycle
	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			dataBits_q <= `DUC_BITS_MIN;
			parityOn_q <= 1'b0;
			parityForced_q <= 1'b0;
			parityValue_q <= 1'b0;
			multidrop_q <= 1'b0;
			stopSixteenths_q <= `DUC_STOP_BASE;
			echoMode_q <= 1'b0;
			localLoop_q <= 1'b0;
			remoteLoop_q <= 1'b0;
		end else begin
			dataBits_q <= `DUC_BITS_MIN + {2'b00, modeOne[1:0]};
			parityOn_q <= (parMode == `DUC_PAR_ON);
			parityForced_q <= (parMode == `DUC_PAR_FORCE);
			multidrop_q <= (parMode == `DUC_PAR_MDROP);
			// odd/even, forced level or address tag; zero when off
			parityValue_q <= modeOne[`DUC_M1_PTYPE] &
				(parMode != `DUC_PAR_OFF);
			stopSixteenths_q <= stopLen(modeTwo[3:0],
				modeOne[1:0] == `DUC_LEN5);
			echoMode_q <= (modeTwo[7:6] == `DUC_CM_ECHO);
			localLoop_q <= (modeTwo[7:6] == `DUC_CM_LLOOP);
			remoteLoop_q <= (modeTwo[7:6] == `DUC_CM_RLOOP);
		end
	end
endmodule

// ===== tb/duc_serial_partner.sv
// remote serial station model facing the channel control block
`timescale 1ns/10ps
module duc_serial_partner (
	input wire clk,
	input wire stall,
	input wire [1:0] rxCharReady,
	input wire [1:0] txCharValid,
	input wire [15:0] txCharData,
	output reg [1:0] rxCharValid,
	output reg [15:0] rxCharData,
	output reg [5:0] rxCharErr,
	output reg [1:0] rxStartBit,
	output reg [1:0] txCharTaken,
	output reg [1:0] txBusy
);
	// ************************************************************
	// state
	// ************************************************************
	reg [15:0] lastTx; // last byte taken per channel
	integer i;
	initial begin
		rxCharValid = 2'b00;
		rxCharData = 16'h0000;
		rxCharErr = 6'h00;
		rxStartBit = 2'b00;
		txCharTaken = 2'b00;
		txBusy = 2'b00;
		lastTx = 16'h0000;
	end
	// offer one channel a character; ok tells whether it was taken
	task offer(input [7:0] d, input [2:0] e, output ok);
		integer n;
		begin
			ok = 1'b0;
			@(posedge clk);
			rxCharValid[0] <= 1'b1;
			rxCharData[7:0] <= d;
			rxCharErr[2:0] <= e;
			// ready is looked at before the edge so no race
			for (n = 0; n < 12 && !ok; n = n + 1) begin
				@(negedge clk);
				ok = rxCharReady[0];
				@(posedge clk);
				// a refused char sees one start bit: overrun case
				rxStartBit[0] <= !ok && n == 0;
			end
			// released lines show the inverse, not the old value
			rxCharValid[0] <= 1'b0;
			rxCharData[7:0] <= ~d;
			rxCharErr[2:0] <= ~e;
		end
	endtask
	// transmit engine: takes a char unless stalled, busy one cycle
	always @(posedge clk) begin
		for (i = 0; i < 2; i = i + 1) begin
			txBusy[i] <= txCharValid[i] && txCharTaken[i];
			if (txCharValid[i] && txCharTaken[i]) begin
				txCharTaken[i] <= 1'b0;
				lastTx[i*8 +: 8] <= txCharData[i*8 +: 8];
			end else begin
				txCharTaken[i] <= txCharValid[i] && !stall;
			end
		end
	end
endmodule

// ===== tb/duc_channel_checker.sv
// concurrent checks on the channel control ports
`timescale 1ns/10ps
module duc_channel_checker (
	input wire clk,
	input wire nrst,
	input wire busSelN,
	input wire busRead,
	input wire [3:0] busAddr,
	input wire [7:0] busWrData,
	input wire [1:0] txCharValid,
	input wire [1:0] txCharTaken,
	input wire [1:0] txEnable,
	input wire [1:0] ctsN,
	input wire [7:0] dataBits,
	input wire [11:0] stopSixteenths,
	input wire [1:0] parityForced,
	input wire [1:0] multidrop,
	input wire [1:0] echoMode,
	input wire [1:0] localLoop,
	input wire [7:0] outputPortPin_q
);
	// ************************************************************
	// helpers
	// ************************************************************
	reg [2:0] upCnt_q; // cycles since reset, format regs lag release
	wire wrA = !busSelN && !busRead;
	wire warm = upCnt_q == 3'h4;
	wire [5:0] stopA = stopSixteenths[5:0];
	wire fiveA = dataBits[3:0] == 4'h5;
	// saturating warm-up counter
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			upCnt_q <= 3'h0;
		end else if (!warm) begin
			upCnt_q <= upCnt_q + 3'h1;
		end
	end
	default clocking dcb @(posedge clk); endclocking
	default disable iff (!nrst);
	// ************************************************************
	// assertions
	// ************************************************************
	a_mode_onehot: assert property (!(echoMode[0] && localLoop[0]))
		else $error("echo and local loop both set");
	a_parity_excl: assert property (!(multidrop[0] && parityForced[0]))
		else $error("multidrop with forced parity");
	a_char_len: assert property (dataBits[3:0] >= 4'h5 && dataBits[3:0] <= 4'h8)
		else $error("character length out of range");
	a_stop_table: assert property (warm |-> (stopA >= 6'h19 && stopA <= 6'h20)
		|| (fiveA ? (stopA >= 6'h11 && stopA <= 6'h18)
		: (stopA >= 6'h09 && stopA <= 6'h10)))
		else $error("stop length outside table");
	a_tx_refuse: assert property (wrA && busAddr == 4'h3 && !txEnable[0]
		&& !txCharValid[0] |=> !txCharValid[0])
		else $error("disabled transmitter was loaded");
	a_tx_load: assert property (wrA && busAddr == 4'h3 && txEnable[0]
		&& !ctsN[0] |=> txCharValid[0])
		else $error("enabled transmitter not loaded");
	a_tx_drop: assert property (txCharValid[0] && txCharTaken[0]
		&& !(wrA && busAddr == 4'h3) |=> !txCharValid[0])
		else $error("holding valid after take");
	a_tx_disable: assert property (wrA && busAddr == 4'h2 && busWrData[3]
		|=> !txEnable[0])
		else $error("transmitter not disabled");
	a_tx_enable: assert property (wrA && busAddr == 4'h2
		&& busWrData[3:2] == 2'b01 && busWrData[6:4] != 3'h3
		|=> txEnable[0])
		else $error("transmitter not enabled");
	a_latch_set: assert property (wrA && busAddr == 4'he && busWrData[1]
		|-> ##[1:2] !outputPortPin_q[1])
		else $error("set latch bit did not drive pin low");
	a_latch_clr: assert property (wrA && busAddr == 4'hf && busWrData[1]
		|-> ##[1:2] outputPortPin_q[1])
		else $error("cleared latch bit did not drive pin high");
	// main scenarios reached
	c_tx_load: cover property (wrA && busAddr == 4'h3 && txEnable[0]);
	c_tx_take: cover property (txCharValid[0] && txCharTaken[0]);
	c_pin_cfg: cover property (wrA && busAddr == 4'hd);
endmodule
bind duc_channel_control duc_channel_checker chk_u (.clk(clk), .nrst(nrst),
	.busSelN(busSelN), .busRead(busRead), .busAddr(busAddr),
	.busWrData(busWrData), .txCharValid(txCharValid),
	.txCharTaken(txCharTaken), .txEnable(txEnable), .ctsN(ctsN),
	.dataBits(dataBits), .stopSixteenths(stopSixteenths),
	.parityForced(parityForced), .multidrop(multidrop),
	.echoMode(echoMode), .localLoop(localLoop),
	.outputPortPin_q(outputPortPin_q));

// ===== tb/testbench.sv
// self-checking bench for the channel control block
`timescale 1ns/10ps
module testbench;
	// ************************************************************
	// signals and instances
	// ************************************************************
	reg clk, nrst, busSelN, busRead, stall, ctOutput, txClk16xA, ok;
	reg [3:0] busAddr;
	reg [7:0] busWrData, rd;
	reg [1:0] ctsN, txClk1x, rxClk1x;
	reg [5:0] expStop;
	integer i, j, k, compares, fail_count;
	wire [7:0] busRdData_q, dataBits, outputPortPin_q;
	wire [1:0] rxCharValid, rxStartBit, rxCharReady, txCharValid;
	wire [1:0] txCharTaken, txBusy, rxEnable, txEnable, parityOn;
	wire [1:0] parityForced, parityValue, multidrop, echoMode;
	wire [1:0] localLoop, remoteLoop, txBreak;
	wire [15:0] rxCharData, txCharData, clockSelect;
	wire [5:0] rxCharErr;
	wire [11:0] stopSixteenths;
	duc_channel_control dut_u (.clk(clk), .nrst(nrst), .busSelN(busSelN),
		.busRead(busRead), .busAddr(busAddr), .busWrData(busWrData),
		.busRdData_q(busRdData_q), .rxCharValid(rxCharValid),
		.rxCharData(rxCharData), .rxCharErr(rxCharErr),
		.rxStartBit(rxStartBit), .rxCharReady(rxCharReady),
		.txCharValid(txCharValid), .txCharData(txCharData),
		.txCharTaken(txCharTaken), .txBusy(txBusy), .ctsN(ctsN),
		.txBreak(txBreak), .rxEnable(rxEnable), .txEnable(txEnable),
		.clockSelect(clockSelect), .dataBits(dataBits),
		.parityOn(parityOn),
		.parityForced(parityForced), .parityValue(parityValue),
		.multidrop(multidrop), .stopSixteenths(stopSixteenths),
		.echoMode(echoMode), .localLoop(localLoop),
		.remoteLoop(remoteLoop), .ctOutput(ctOutput),
		.txClk16xA(txClk16xA), .txClk1x(txClk1x), .rxClk1x(rxClk1x),
		.outputPortPin_q(outputPortPin_q));
	duc_serial_partner partner_u (.clk(clk), .stall(stall),
		.rxCharReady(rxCharReady), .txCharValid(txCharValid),
		.txCharData(txCharData), .rxCharValid(rxCharValid),
		.rxCharData(rxCharData), .rxCharErr(rxCharErr),
		.rxStartBit(rxStartBit), .txCharTaken(txCharTaken),
		.txBusy(txBusy));
	// ************************************************************
	// tasks
	// ************************************************************
	task chk8(input [7:0] got, input [7:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("[ERR] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// one bus access, strobe low for exactly one edge
	task busAcc(input rw, input [3:0] a, input [7:0] d);
		begin
			@(posedge clk);
			busSelN <= 1'b0;
			busRead <= rw;
			busAddr <= a;
			busWrData <= d;
			@(posedge clk);
			busSelN <= 1'b1;
			busWrData <= ~d;
			@(negedge clk);
			rd = busRdData_q;
		end
	endtask
	// command write, then three more clock edges before the next step
	task cmdWr(input [3:0] a, input [7:0] d);
		begin
			busAcc(1'b0, a, d);
			repeat (3) @(posedge clk);
		end
	endtask
	// pointer reset, then mode one and mode two of channel a
	task setMode(input [7:0] m1, input [7:0] m2);
		begin
			cmdWr(4'h2, 8'h10);
			busAcc(1'b0, 4'h0, m1);
			busAcc(1'b0, 4'h0, m2);
			repeat (3) @(negedge clk);
		end
	endtask
	task finish_test;
		begin
			$display("compares %0d errors %0d", compares, fail_count);
			if (fail_count == 0 && compares > 0) begin
				$display("TB: PASS");
			end else begin
				$display("TB: FAIL");
			end
			$finish;
		end
	endtask
	// ************************************************************
	// stimulus
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		nrst = 1'b0;
		busSelN = 1'b1;
		busRead = 1'b0;
		busAddr = 4'h0;
		busWrData = 8'h00;
		ctsN = 2'b00;
		stall = 1'b0;
		ctOutput = 1'b1;
		txClk16xA = 1'b0;
		txClk1x = 2'b01;
		rxClk1x = 2'b10;
		compares = 0;
		fail_count = 0;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		repeat (5) @(negedge clk);
		chk8(outputPortPin_q, 8'hff);
		// mode pointer walks from one to two and stays
		setMode(8'h13, 8'h07);
		busAcc(1'b1, 4'h0, 8'h00);
		chk8(rd, 8'h07);
		cmdWr(4'h2, 8'h10);
		busAcc(1'b1, 4'h0, 8'h00);
		chk8(rd, 8'h13);
		busAcc(1'b1, 4'h0, 8'h00);
		chk8(rd, 8'h07);
		// every length with every stop code
		for (i = 0; i < 4; i = i + 1) begin
			for (j = 0; j < 16; j = j + 1) begin
				setMode({6'h04, i[1:0]}, {4'h0, j[3:0]});
				expStop = {2'b00, j[3:0]} + (j[3] ? 6'h11 : 6'h09);
				if (!j[3] && i == 0) expStop = expStop + 6'h08;
				chk8({2'b00, stopSixteenths[5:0]}, {2'b00, expStop});
				chk8({4'h0, dataBits[3:0]}, {6'h00, i[1:0]} + 8'h05);
			end
		end
		// parity modes and channel modes
		for (i = 0; i < 4; i = i + 1) begin
			setMode({3'b000, i[1:0], 3'b111}, {i[1:0], 6'h07});
			chk8({6'h00, multidrop[0], parityForced[0]}, {6'h00, i == 3, i == 1});
			if (i != 1) chk8({7'h00, parityOn[0]}, {7'h00, i == 0});
			if (i != 2) chk8({7'h00, parityValue[0]}, 8'h01);
			chk8({5'h00, remoteLoop[0], localLoop[0], echoMode[0]}, (8'h01 << i) >> 1);
		end
		// transmitter: refused while disabled, stands while stalled
		// receiver flow control on for the fifo test below
		setMode(8'h93, 8'h07);
		busAcc(1'b0, 4'h3, 8'h11);
		repeat (3) @(negedge clk);
		chk8({7'h00, txCharValid[0]}, 8'h00);
		stall = 1'b1;
		cmdWr(4'h2, 8'h04);
		chk8({7'h00, txEnable[0]}, 8'h01);
		busAcc(1'b0, 4'h3, 8'h5a);
		repeat (4) @(negedge clk);
		chk8({7'h00, txCharValid[0]}, 8'h01);
		stall = 1'b0;
		for (k = 0; k < 20 && txCharValid[0] !== 1'b0; k = k + 1) @(negedge clk);
		if (k == 20) begin
			fail_count = fail_count + 1;
			$display("[ERR] %0t transmit char never taken", $time);
			finish_test;
		end
		chk8(partner_u.lastTx[7:0], 8'h5a);
		// break on and off, clock select lands on a status write
		cmdWr(4'h2, 8'h60);
		chk8({7'h00, txBreak[0]}, 8'h01);
		cmdWr(4'h2, 8'h70);
		chk8({7'h00, txBreak[0]}, 8'h00);
		busAcc(1'b0, 4'h1, 8'h5c);
		chk8(clockSelect[7:0], 8'h5c);
		// output pins from latch, then from status and clocks
		busAcc(1'b0, 4'hd, 8'h00);
		busAcc(1'b0, 4'he, 8'hff);
		repeat (2) @(negedge clk);
		chk8(outputPortPin_q, 8'h00);
		busAcc(1'b0, 4'hf, 8'hf0);
		repeat (2) @(negedge clk);
		chk8(outputPortPin_q, 8'hf0);
		busAcc(1'b0, 4'hf, 8'h0f);
		cmdWr(4'ha, 8'h04);
		busAcc(1'b0, 4'hd, 8'hc0);
		repeat (2) @(negedge clk);
		chk8({6'h00, outputPortPin_q[7:6]}, 8'h00);
		for (i = 0; i < 4; i = i + 1) begin
			busAcc(1'b0, 4'hd, {4'h0, i[1:0], i[1:0]});
			repeat (2) @(negedge clk);
			chk8({6'h00, outputPortPin_q[3:2]}, {6'h00,
				(4'b0101 >> i & 1) != 0,
				(4'b1011 >> i & 1) != 0});
		end
		// receive fifo filled to refusal, errors ride with chars
		cmdWr(4'h2, 8'h01);
		busAcc(1'b0, 4'hd, 8'h10);
		busAcc(1'b0, 4'he, 8'h01);
		for (i = 0; i < 8; i = i + 1) begin
			partner_u.offer({5'h06, i[2:0]}, i == 0 ? 3'h5 : i == 1 ? 3'h2 : 3'h0, ok);
			chk8({7'h00, ok}, 8'h01);
		end
		partner_u.offer(8'h99, 3'h0, ok);
		chk8({7'h00, ok}, 8'h00);
		chk8({7'h00, outputPortPin_q[4]}, 8'h00);
		chk8({7'h00, outputPortPin_q[0]}, 8'h01);
		busAcc(1'b1, 4'h1, 8'h00);
		chk8(rd & 8'hf3, 8'hb3);
		busAcc(1'b1, 4'h3, 8'h00);
		chk8(rd, 8'h30);
		busAcc(1'b1, 4'h1, 8'h00);
		chk8(rd & 8'hf3, 8'h51);
		chk8({7'h00, outputPortPin_q[0]}, 8'h00);
		cmdWr(4'h2, 8'h40);
		busAcc(1'b1, 4'h1, 8'h00);
		chk8(rd & 8'he0, 8'h00);
		cmdWr(4'h2, 8'h20);
		busAcc(1'b1, 4'h1, 8'h00);
		chk8(rd & 8'h03, 8'h00);
		// block mode keeps the flag after its char is gone
		setMode(8'h73, 8'h07);
		cmdWr(4'h2, 8'h01);
		partner_u.offer(8'h41, 3'h4, ok);
		partner_u.offer(8'h42, 3'h0, ok);
		chk8({7'h00, outputPortPin_q[4]}, 8'h01);
		busAcc(1'b1, 4'h3, 8'h00);
		chk8(rd, 8'h41);
		busAcc(1'b1, 4'h1, 8'h00);
		chk8(rd & 8'he0, 8'h80);
		cmdWr(4'h2, 8'h40);
		busAcc(1'b1, 4'h1, 8'h00);
		chk8(rd & 8'he0, 8'h00);
		finish_test;
	end
endmodule
